// ### mhl_pkg.sv
// Package for the modem handshake line block: timing constants and states.
// Assumes a 50 MHz clock on the device side.
package mhl_pkg;
    // =========================================================
    // Clock and timing
    // =========================================================
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned RING_LOW_MS       = 100;
    localparam int unsigned RING_LOW_CYCLES   = RING_LOW_MS * (CLK_HZ / 1000);
    // Shutdown pulse window: 100 +- 25 ms, accepted from the minimum
    localparam int unsigned SD_PULSE_MIN_MS   = 75;
    localparam int unsigned SD_PULSE_MIN_CYC  = SD_PULSE_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned SD_PULSE_MAX_MS   = 125;
    localparam int unsigned SD_PULSE_MAX_CYC  = SD_PULSE_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W             = 32;

    // =========================================================
    // Call and shutdown states
    // =========================================================
    typedef enum logic [1:0] {MHL_IDLE, MHL_PREP, MHL_CONN} mhl_call_t;
    typedef enum logic [1:0] {MHL_SD_IDLE, MHL_SD_PULSE, MHL_SD_ACK, MHL_SD_OFF} mhl_sd_t;
endpackage : mhl_pkg

// ### mhl_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mhl_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clock,     // System clock
    input  wire logic srst,      // Synchronous reset
    input  wire logic pin,       // Asynchronous pin level
    output var  logic level      // Filtered level
);
    logic s1;
    logic s2;
    logic s3;

    // First stage feeds only the second; level moves when stages 2 and 3 agree
    always_ff @(posedge clock) begin
        if (srst) begin
            s1    <= RESET_VAL;
            s2    <= RESET_VAL;
            s3    <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule : mhl_sync
`default_nettype wire

// ### mhl_lines.sv
// Device-side handshake lines of a cellular data module (DCE end).
// Assumes host pins arrive asynchronously; call events come from modem logic.
//
// Contract
// R1: Host drives rts low when accepting data.
// R2: Clear-to-send high until ready, then low.
// R3: Host holds dtr low during data call.
// R4: Rising dtr ends call, module goes on-hook.
// R5: Asserted dtr prepares modem, keeps connection.
// R6: Carrier-detect high by default, low on connect.
// R7: Carrier-detect returns high at disconnect.
// R8: Ring indicator falls, stays low 100 ms.
// R9: Host enables power with power_enable_n low.
// R10: Shutdown line is open-collector, both may pull.
// R11: Flow control on by default; txd idles high.
// R12: Shutdown pulse acknowledged low until power-down.
// R13: Host synchronises status inputs before edges.
`timescale 1ns/1ps
`default_nettype none
module mhl_lines
    import mhl_pkg::*;
#(
    parameter int unsigned RING_CYCLES = RING_LOW_CYCLES,   // Ring low time
    parameter int unsigned SD_MIN_CYC  = SD_PULSE_MIN_CYC,  // Shortest shutdown pulse
    parameter int unsigned SD_MAX_CYC  = SD_PULSE_MAX_CYC   // Longest shutdown pulse
) (
    input  wire logic clock,              // 50 MHz clock
    input  wire logic srst,               // Synchronous reset
    input  wire logic rts_n,              // Host request-to-send pin
    input  wire logic dtr_n,              // Host data-terminal-ready pin
    input  wire logic power_enable_n,     // Host power enable pin
    input  wire logic data_to_module,     // Host transmit data pin
    input  wire logic sd_line_in,         // Shutdown line level
    output var  logic sd_line_out,        // Shutdown drive value (always low)
    output var  logic sd_line_oe,         // Shutdown pull-down enable
    output var  logic cts_n,              // Clear-to-send pin
    output var  logic dcd_n,              // Carrier-detect pin
    output var  logic ri_n,               // Ring indicator pin
    input  wire logic rx_ready,           // Modem can take host data
    input  wire logic connect_seen,       // Connect result from remote
    input  wire logic carrier_lost,       // Remote connection dropped
    input  wire logic incoming_event,     // Voice, data call or message pulse
    input  wire logic power_down_done,    // Internal power-down finished
    output var  logic host_may_send,      // Host accepts data, flow control
    output var  logic modem_prepare,      // Prepare modem for line
    output var  logic call_active,        // Data call connected
    output var  logic hang_up,            // One-cycle on-hook pulse
    output var  logic power_down_req,     // Shutdown accepted, power down
    output var  logic powered,            // Power enabled by host
    output var  logic txd_idle_ok         // Host transmit line idles high
);
    // =========================================================
    // Pin synchronisers
    // =========================================================
    logic rts_s;
    logic dtr_s;
    logic pwr_s;
    logic txd_s;
    logic sd_s;

    // Starts as not accepting, so flow control never opens before the pin is seen
    mhl_sync #(.RESET_VAL(1'b1)) u_rts (.clock(clock), .srst(srst), .pin(rts_n),
        .level(rts_s));
    mhl_sync #(.RESET_VAL(1'b1)) u_dtr (.clock(clock), .srst(srst), .pin(dtr_n),
        .level(dtr_s));
    mhl_sync #(.RESET_VAL(1'b1)) u_pwr (.clock(clock), .srst(srst), .pin(power_enable_n),
        .level(pwr_s));
    mhl_sync #(.RESET_VAL(1'b1)) u_txd (.clock(clock), .srst(srst), .pin(data_to_module),
        .level(txd_s));
    mhl_sync #(.RESET_VAL(1'b1)) u_sd (.clock(clock), .srst(srst), .pin(sd_line_in),
        .level(sd_s));

    // =========================================================
    // Host level decode
    // =========================================================
    logic dtr_q;
    wire  dtr_rise    = dtr_s & ~dtr_q;                          // [R4]
    wire  dtr_on      = ~dtr_s;                                  // [R3]
    wire  next_flow   = ~rts_s;                                  // [R1] [R11]

    always_ff @(posedge clock) begin
        if (srst) begin
            dtr_q         <= 1'b1;
            host_may_send <= 1'b0;
            powered       <= 1'b0;
            txd_idle_ok   <= 1'b1;
        end else begin
            dtr_q         <= dtr_s;
            host_may_send <= next_flow;                          // [R1] [R11]
            powered       <= ~pwr_s;                             // [R9]
            txd_idle_ok   <= txd_s;                              // [R11]
        end
    end

    // =========================================================
    // Data call control
    // =========================================================
    mhl_call_t call_st;
    mhl_call_t next_call;

    always_comb begin
        next_call = call_st;
        case (call_st)
            MHL_IDLE: begin
                if (dtr_on) begin
                    next_call = MHL_PREP;                        // [R5]
                end
            end
            MHL_PREP: begin
                if (dtr_rise || !dtr_on) begin
                    next_call = MHL_IDLE;                        // [R4]
                end else if (connect_seen) begin
                    next_call = MHL_CONN;                        // [R6]
                end
            end
            MHL_CONN: begin
                if (dtr_rise || carrier_lost) begin
                    next_call = MHL_IDLE;                        // [R4] [R7]
                end
            end
            default: begin
                next_call = MHL_IDLE;
            end
        endcase
    end

    wire hang_now = (call_st != MHL_IDLE) && (next_call == MHL_IDLE);

    always_ff @(posedge clock) begin
        if (srst) begin
            call_st       <= MHL_IDLE;
            dcd_n         <= 1'b1;
            cts_n         <= 1'b1;
            modem_prepare <= 1'b0;
            call_active   <= 1'b0;
            hang_up       <= 1'b0;
        end else begin
            call_st       <= next_call;
            dcd_n         <= (next_call != MHL_CONN);            // [R6] [R7]
            cts_n         <= ~rx_ready;                          // [R2]
            modem_prepare <= (next_call != MHL_IDLE);            // [R5]
            call_active   <= (next_call == MHL_CONN);            // [R5]
            hang_up       <= hang_now;                           // [R4]
        end
    end

    // =========================================================
    // Ring indicator
    // =========================================================
    // Events during a running pulse are merged into it
    logic [CNT_W-1:0] ring_cnt;
    wire              ring_busy = (ring_cnt != '0);

    always_ff @(posedge clock) begin
        if (srst) begin
            ring_cnt <= '0;
            ri_n     <= 1'b1;
        end else begin
            if (incoming_event && !ring_busy) begin
                ring_cnt <= CNT_W'(RING_CYCLES);                 // [R8]
                ri_n     <= 1'b0;                                // [R8]
            end else if (ring_busy) begin
                ring_cnt <= ring_cnt - CNT_W'(1);
                ri_n     <= (ring_cnt == CNT_W'(1));             // [R8]
            end
        end
    end

    // =========================================================
    // Hardware shutdown handshake
    // =========================================================
    mhl_sd_t          sd_st;
    logic [CNT_W-1:0] sd_cnt;
    wire              sd_low      = ~sd_s;
    wire              pulse_ok    = (sd_cnt >= CNT_W'(SD_MIN_CYC)) &&
                                    (sd_cnt <= CNT_W'(SD_MAX_CYC));
    wire              cnt_sat     = (sd_cnt == CNT_W'(SD_MAX_CYC + 1));

    always_ff @(posedge clock) begin
        if (srst) begin
            sd_st          <= MHL_SD_IDLE;
            sd_cnt         <= '0;
            sd_line_oe     <= 1'b0;
            power_down_req <= 1'b0;
        end else begin
            case (sd_st)
                MHL_SD_IDLE: begin
                    sd_cnt <= '0;
                    if (sd_low) begin
                        sd_st <= MHL_SD_PULSE;
                    end
                end
                MHL_SD_PULSE: begin
                    // Pulses out of window are ignored
                    if (!sd_low) begin
                        sd_st <= pulse_ok ? MHL_SD_ACK : MHL_SD_IDLE;   // [R12]
                        if (pulse_ok) begin
                            sd_line_oe     <= 1'b1;                     // [R10] [R12]
                            power_down_req <= 1'b1;
                        end
                    end else if (!cnt_sat) begin
                        sd_cnt <= sd_cnt + CNT_W'(1);
                    end
                end
                MHL_SD_ACK: begin
                    if (power_down_done) begin
                        sd_line_oe <= 1'b0;                      // [R12]
                        sd_st      <= MHL_SD_OFF;
                    end
                end
                MHL_SD_OFF: begin
                    // Held off until host removes power
                    if (pwr_s) begin
                        power_down_req <= 1'b0;
                        sd_st          <= MHL_SD_IDLE;
                    end
                end
                default: begin
                    sd_st <= MHL_SD_IDLE;
                end
            endcase
        end
    end

    assign sd_line_out = 1'b0;                                   // [R10]
endmodule : mhl_lines
`default_nettype wire

// ### mhl_lines_checker.sv
// Checker for the handshake line block, watching top-level ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mhl_lines_checker
    import mhl_pkg::*;
#(
    parameter int unsigned RING_CYCLES = RING_LOW_CYCLES  // Ring low time
) (
    input wire logic clock,           // Clock
    input wire logic srst,            // Reset
    input wire logic dtr_n,           // Terminal ready pin
    input wire logic rx_ready,        // Modem ready
    input wire logic connect_seen,    // Connect result
    input wire logic carrier_lost,    // Remote dropped
    input wire logic incoming_event,  // Ring cause
    input wire logic power_down_done, // Power-down over
    input wire logic sd_line_oe,      // Shutdown pull
    input wire logic cts_n,           // Clear to send
    input wire logic dcd_n,           // Carrier detect
    input wire logic ri_n,            // Ring indicator
    input wire logic modem_prepare,   // Preparing
    input wire logic call_active,     // Connected
    input wire logic hang_up,         // On-hook pulse
    input wire logic power_down_req   // Shutdown taken
);
    int unsigned ring_low;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Counts low cycles so the ring length is checked exactly
    always_ff @(posedge clock) begin
        ring_low <= (srst || ri_n) ? 0 : ring_low + 1;
    end
    property p_cts; $changed(rx_ready) |=> cts_n != $past(rx_ready); endproperty
    a_cts: assert property (p_cts) else $error("cts did not follow ready");
    property p_ring; $fell(ri_n) |-> $past(incoming_event); endproperty
    a_ring: assert property (p_ring) else $error("ring fell without event");
    property p_ring_len; $rose(ri_n) |-> ring_low == RING_CYCLES; endproperty
    a_ring_len: assert property (p_ring_len) else $error("ring length wrong");
    property p_dcd; $fell(dcd_n) |-> $past(connect_seen) && $past(modem_prepare); endproperty
    a_dcd: assert property (p_dcd) else $error("carrier low without connect");
    property p_lost; call_active && carrier_lost |=> dcd_n && hang_up; endproperty
    a_lost: assert property (p_lost) else $error("carrier kept after loss");
    property p_hang; $rose(dtr_n) && call_active |-> ##[1:7] hang_up; endproperty
    a_hang: assert property (p_hang) else $error("no on-hook after ready rose");
    property p_prep; !dtr_n [*8] |-> modem_prepare || hang_up; endproperty
    a_prep: assert property (p_prep) else $error("no prepare while ready low");
    property p_sd_ack; $rose(sd_line_oe) |-> power_down_req; endproperty
    a_sd_ack: assert property (p_sd_ack) else $error("ack without request");
    property p_sd_off; sd_line_oe && power_down_done |=> !sd_line_oe; endproperty
    a_sd_off: assert property (p_sd_off) else $error("ack held after power-down");
endmodule : mhl_lines_checker
bind mhl_lines mhl_lines_checker #(.RING_CYCLES(RING_CYCLES)) u_mhl_lines_checker (.clock,
    .srst, .dtr_n, .rx_ready, .connect_seen, .carrier_lost, .incoming_event, .power_down_done,
    .sd_line_oe, .cts_n, .dcd_n, .ri_n, .modem_prepare, .call_active, .hang_up, .power_down_req);
`default_nettype wire

// ### mhl_host.sv
// Host model: terminal side driving the handshake pins.
// Assumes bench commands; the shutdown wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module mhl_host (
    input  wire logic       clock,          // Clock
    input  wire logic       call_req,       // Want a call
    input  wire logic       accept,         // Can take data
    input  wire logic       sd_go,          // Start shutdown pulse
    input  wire logic [7:0] sd_len,         // Pulse cycles
    input  wire logic       sd_line_oe,     // Module pull
    output var  logic       rts_n,          // Request to send
    output var  logic       dtr_n,          // Terminal ready
    output var  logic       power_enable_n, // Power enable
    output var  logic       data_to_module, // Transmit data
    output var  logic       sd_line_in      // Resolved wire
);
    logic [7:0] cnt = 8'h00;
    logic [1:0] st = 2'h0;
    logic [1:0] syn = 2'h3;
    assign rts_n = !accept;
    assign dtr_n = !call_req;
    assign data_to_module = 1'b1;
    // Open collector both ways; pull-up wins when nobody pulls
    assign sd_line_in = !(cnt != 8'h00 || sd_line_oe);
    initial power_enable_n = 1'b0;
    always @(posedge clock) begin
        syn <= {syn[0], sd_line_in};
        if (sd_go) begin
            cnt <= sd_len;
            st <= 2'h1;
        end else if (cnt != 8'h00) cnt <= cnt - 8'h01;
        else if (st == 2'h1 && syn[1]) st <= 2'h2;
        else if (st == 2'h2 && !syn[1]) st <= 2'h3;
        else if (st == 2'h3 && syn[1]) begin
            st <= 2'h0;
            power_enable_n <= 1'b1;
        end
    end
endmodule : mhl_host
`default_nettype wire

// ### mhl_lines_bench.sv
// Self-checking bench for the handshake lines with a host model.
// Assumes ring and shutdown counts shortened through parameters.
`timescale 1ns/1ps
`default_nettype none
module mhl_lines_bench;
    localparam int unsigned RC = 20;
    logic clock = 1'b0, srst = 1'b1, call_req = 1'b0, accept = 1'b0, sd_go = 1'b0;
    logic rx_ready = 1'b0, connect_seen = 1'b0, carrier_lost = 1'b0, incoming_event = 1'b0;
    logic power_down_done = 1'b0;
    logic [7:0] sd_len = 8'h00;
    logic rts_n, dtr_n, power_enable_n, data_to_module, sd_line_in, sd_line_out, sd_line_oe;
    logic cts_n, dcd_n, ri_n, host_may_send, modem_prepare, call_active, hang_up;
    logic power_down_req, powered, txd_idle_ok;
    logic [7:0] obs, last, want;
    logic [7:0] notes[$];
    int miscompares = 0, compares = 0, seed = 32'he736;
    assign obs = {cts_n, dcd_n, ri_n, modem_prepare, hang_up, sd_line_oe, power_down_req, powered};
    always #10 clock = ~clock;
    mhl_lines #(.RING_CYCLES(RC), .SD_MIN_CYC(10), .SD_MAX_CYC(30)) u_mhl_lines (.clock, .srst,
        .rts_n, .dtr_n, .power_enable_n, .data_to_module, .sd_line_in, .sd_line_out, .sd_line_oe,
        .cts_n, .dcd_n, .ri_n, .rx_ready, .connect_seen, .carrier_lost, .incoming_event,
        .power_down_done, .host_may_send, .modem_prepare, .call_active, .hang_up,
        .power_down_req, .powered, .txd_idle_ok);
    mhl_host u_mhl_host (.clock, .call_req, .accept, .sd_go, .sd_len, .sd_line_oe, .rts_n,
        .dtr_n, .power_enable_n, .data_to_module, .sd_line_in);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    // Expected output word after the change, oldest first
    task automatic note(input logic [7:0] m, input logic [7:0] v);
        want = (want & ~m) | v;
        notes.push_back(want);
    endtask : note
    // Bounded drain: a stuck queue ends the run
    task automatic step(input string name);
        for (int i = 0; i < 300 && notes.size() != 0; i++) tick(1);
        if (notes.size() != 0) begin
            chk(8'h00, 8'h01, "drain timeout");
            report_and_stop();
        end
        $display("test %s done", name);
    endtask : step
    task automatic call_up();
        call_req = 1'b1;
        note(8'h10, 8'h10);
        tick(8);
        connect_seen = 1'b1;
        note(8'h40, 8'h00);
        tick(1);
        connect_seen = 1'b0;
        tick(3);
    endtask : call_up
    always @(negedge clock) begin
        if (!srst && obs !== last) begin
            if (notes.size() == 0) chk(obs, last, "unexpected change");
            else chk(obs, notes.pop_front(), "outputs");
            last = obs;
        end
    end
    initial begin
        want = 8'he0;
        last = 8'he0;
        tick(6);
        srst = 1'b0;
        chk(obs, 8'he0, "reset word");
        tick(1);
        chk({7'h00, host_may_send}, 8'h00, "may send after reset");
        note(8'h01, 8'h01);
        step("reset");
        chk({7'h00, txd_idle_ok}, 8'h01, "txd idle");
        accept = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rx_ready = 1'($random(seed));
            if (rx_ready == want[7]) note(8'h80, {!rx_ready, 7'h00});
            tick(1);
        end
        step("flow");
        chk({7'h00, host_may_send}, 8'h01, "may send");
        connect_seen = 1'b1;
        tick(1);
        connect_seen = 1'b0;
        call_up();
        chk({7'h00, call_active}, 8'h01, "call active");
        call_req = 1'b0;
        note(8'h58, 8'h48);
        note(8'h08, 8'h00);
        step("call");
        chk({7'h00, call_active}, 8'h00, "call ended");
        call_up();
        carrier_lost = 1'b1;
        note(8'h58, 8'h48);
        note(8'h18, 8'h10);
        tick(1);
        carrier_lost = 1'b0;
        tick(3);
        chk({7'h00, call_active}, 8'h00, "call after loss");
        call_req = 1'b0;
        note(8'h18, 8'h08);
        note(8'h08, 8'h00);
        step("carrier");
        incoming_event = 1'b1;
        note(8'h20, 8'h00);
        tick(1);
        incoming_event = 1'b0;
        tick(5);
        incoming_event = 1'b1;
        tick(1);
        incoming_event = 1'b0;
        note(8'h20, 8'h20);
        step("ring");
        sd_len = 8'h05;
        sd_go = 1'b1;
        tick(1);
        sd_go = 1'b0;
        tick(40);
        sd_len = 8'h14;
        sd_go = 1'b1;
        note(8'h06, 8'h06);
        tick(1);
        sd_go = 1'b0;
        step("shutdown ack");
        chk({7'h00, sd_line_out}, 8'h00, "shutdown drive");
        power_down_done = 1'b1;
        note(8'h04, 8'h00);
        note(8'h03, 8'h00);
        tick(1);
        power_down_done = 1'b0;
        step("power off");
        report_and_stop();
    end
endmodule : mhl_lines_bench
`default_nettype wire
